// ==== hdl/epcf_pkg.sv ====
// Shared constants and types of the external and pin change interrupt flag block.
package epcf_pkg;

  // ----------------------------------------------------------------------
  // Register offsets in data space
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_CHANGE_FLAGS = 8'h3b;
  localparam logic [7:0] ADDR_EXTERNAL_IRQ_FLAGS = 8'h3c;
  localparam logic [7:0] ADDR_PIN_CHANGE_GROUP_ENABLE = 8'h68;
  localparam logic [7:0] ADDR_PIN_CHANGE_MASK_GROUP0 = 8'h6b;
  localparam logic [7:0] ADDR_PIN_CHANGE_MASK_GROUP1 = 8'h6c;
  localparam logic [7:0] ADDR_PIN_CHANGE_MASK_GROUP2 = 8'h6d;

  // ----------------------------------------------------------------------
  // I/O space window, shifted down from data space
  // ----------------------------------------------------------------------
  localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
  localparam logic [7:0] IO_SPACE_LIMIT = 8'h3f;

  // ----------------------------------------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] RESET_GROUP_ENABLE = 8'h00;
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [7:0] EXT_FLAGS_VALID = 8'h03;
  localparam logic [7:0] GROUP_FLAGS_VALID = 8'h07;
  localparam logic [7:0] GROUP_ENABLE_VALID = 8'h07;
  localparam logic [7:0] MASK_GROUP0_VALID = 8'hff;
  localparam logic [7:0] MASK_GROUP1_VALID = 8'h7f;
  localparam logic [7:0] MASK_GROUP2_VALID = 8'hff;

  // ----------------------------------------------------------------------
  // Field positions and source numbering
  // ----------------------------------------------------------------------
  localparam int EXT_FLAG_0_BIT = 0;
  localparam int EXT_FLAG_1_BIT = 1;
  localparam int GROUP0_BIT = 0;
  localparam int GROUP1_BIT = 1;
  localparam int GROUP2_BIT = 2;
  localparam int GROUP_WIDTH = 8;
  localparam int NUM_GROUPS = 3;
  localparam int NUM_EXT = 2;
  localparam int NUM_SOURCES = 5;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_GROUP0 = 2;
  localparam int SRC_GROUP1 = 3;
  localparam int SRC_GROUP2 = 4;
  localparam int CHANGE_PINS = 24;

  // Sense control codes of an external pin.
  typedef enum logic [1:0] {
    EPCF_SENSE_LOW = 2'b00,
    EPCF_SENSE_CHANGE = 2'b01,
    EPCF_SENSE_FALL = 2'b10,
    EPCF_SENSE_RISE = 2'b11
  } epcf_sense_t;

endpackage

// ==== hdl/epcf_pin_watch.sv ====
// Two-flop pin synchroniser with sampled level and edge pulses.
`timescale 1ns/10ps
module epcf_pin_watch #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  // The first stage feeds only the second, so a metastable sample never
  // reaches the edge logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
    end else if (ce) begin
      meta <= pin_in;
      sync <= meta;
    end
  end

  // Previous sample, compared with the current one to find changes.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= '0;
    end else if (ce) begin
      prev <= sync;
    end
  end

  // A pulse longer than one clock is caught by this comparison while ce stays high.
  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule

// ==== hdl/epcf_top.sv ====
// External pin and pin change interrupt flags, enables, masks and requests.
`timescale 1ns/10ps
// Notes on behaviour
// - Selected external pin event sets its flag.
// - Flag (low pin when level sensed), enable and global enable request vector.
// - Vector acknowledge clears the matching flag.
// - Writing one clears a flag; zero ignored.
// - Level sensing holds the external flag zero.
// - Group 2 needs group and global enable.
// - Group 1 covers pins 14:8, gated likewise.
// - Group 0 covers pins 7:0, gated likewise.
// - Any enabled pin change sets group flag.
// - Mask bit enables pin, only with group.
// - Cleared mask bit blocks that pin.
// - Flags reachable in data and I/O space.
// - Sense codes: low, change, falling, rising.
// - Pins sampled; pulses over one clock caught with CE high.
// - Pins driven as outputs still interrupt.
module epcf_top
  import epcf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic IO_SPACE,
  input wire logic WR_EN,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  input wire logic [epcf_pkg::NUM_EXT-1:0] EXT_PIN,
  input wire logic [1:0] SENSE_SELECT_0,
  input wire logic [1:0] SENSE_SELECT_1,
  input wire logic [epcf_pkg::NUM_EXT-1:0] EXTERNAL_IRQ_ENABLE_MASK,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [epcf_pkg::CHANGE_PINS-1:0] CHANGE_WATCH_PIN,
  input wire logic [epcf_pkg::NUM_SOURCES-1:0] VECTOR_ACK,
  output logic [epcf_pkg::NUM_SOURCES-1:0] IRQ_REQ
);
  import epcf_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Maps an access to its data space address; out-of-window I/O gives 0.
  function automatic logic [7:0] data_addr(input logic [7:0] a, input logic io);
    logic [7:0] r;
    r = a;
    if (io) begin
      r = (a <= IO_SPACE_LIMIT) ? 8'(a + IO_SPACE_OFFSET) : 8'h00;
    end
    return r;
  endfunction

  // Event decode of one external pin from its sense code.
  function automatic logic ext_event(input logic [1:0] s, input logic r, input logic f);
    logic e;
    e = 1'b0;
    case (epcf_sense_t'(s))
      EPCF_SENSE_LOW: e = 1'b0;
      EPCF_SENSE_CHANGE: e = r | f;
      EPCF_SENSE_FALL: e = f;
      EPCF_SENSE_RISE: e = r;
      default: e = 1'b0;
    endcase
    return e;
  endfunction

  // Any unmasked change within one group of pins.
  function automatic logic group_change(input logic [7:0] chg, input logic [7:0] msk);
    return |(chg & msk);
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] ext_flags;
  logic [7:0] group_flags;
  logic [7:0] group_enable;
  logic [7:0] mask_group0;
  logic [7:0] mask_group1;
  logic [7:0] mask_group2;
  logic [7:0] next_ext_flags;
  logic [7:0] next_group_flags;
  logic [7:0] next_rd_data;
  logic [7:0] acc_addr;
  logic wr_ext_flags;
  logic wr_group_flags;
  logic [NUM_EXT-1:0] ext_level;
  logic [NUM_EXT-1:0] ext_rise;
  logic [NUM_EXT-1:0] ext_fall;
  logic [CHANGE_PINS-1:0] pin_rise;
  logic [CHANGE_PINS-1:0] pin_fall;
  logic [CHANGE_PINS-1:0] pin_change;
  logic [NUM_EXT-1:0] ext_set;
  logic [NUM_EXT-1:0] ext_is_level;
  logic [NUM_GROUPS-1:0] group_set;
  logic [1:0] sense [NUM_EXT];

  assign sense[0] = SENSE_SELECT_0;
  assign sense[1] = SENSE_SELECT_1;

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  // Pins are watched from the pad side, so a pin driven as an output by
  // the port logic still raises its events.
  epcf_pin_watch #(
    .W(NUM_EXT)
  ) u_ext_watch (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pin_in(EXT_PIN),
    .level(ext_level),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  epcf_pin_watch #(
    .W(CHANGE_PINS)
  ) u_change_watch (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pin_in(CHANGE_WATCH_PIN),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign pin_change = pin_rise | pin_fall;

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  // External events per sense code; level mode produces no flag event.
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_set[i] = ext_event(sense[i], ext_rise[i], ext_fall[i]);
      ext_is_level[i] = (sense[i] == EPCF_SENSE_LOW);
    end
  end

  // Group events need the group enable and a set mask bit per pin.
  // Pin 15 has no mask bit, so it never contributes to group 1.
  always_comb begin
    group_set[GROUP0_BIT] = group_enable[GROUP0_BIT] &
      group_change(pin_change[7:0], mask_group0);
    group_set[GROUP1_BIT] = group_enable[GROUP1_BIT] &
      group_change(pin_change[15:8], mask_group1);
    group_set[GROUP2_BIT] = group_enable[GROUP2_BIT] &
      group_change(pin_change[23:16], mask_group2);
  end

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  assign acc_addr = data_addr(ADDR, IO_SPACE);
  assign wr_ext_flags = WR_EN && (acc_addr == ADDR_EXTERNAL_IRQ_FLAGS);
  assign wr_group_flags = WR_EN && (acc_addr == ADDR_PIN_CHANGE_FLAGS);

  // ----------------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------------
  // The set term is ORed in after the write and acknowledge clears so an event in the clearing cycle stays.
  always_comb begin
    next_ext_flags = ext_flags;
    if (wr_ext_flags) begin
      next_ext_flags = next_ext_flags & ~WR_DATA;
    end
    if (VECTOR_ACK[SRC_EXT0]) begin
      next_ext_flags[EXT_FLAG_0_BIT] = 1'b0;
    end
    if (VECTOR_ACK[SRC_EXT1]) begin
      next_ext_flags[EXT_FLAG_1_BIT] = 1'b0;
    end
    next_ext_flags[EXT_FLAG_0_BIT] = next_ext_flags[EXT_FLAG_0_BIT] | ext_set[0];
    next_ext_flags[EXT_FLAG_1_BIT] = next_ext_flags[EXT_FLAG_1_BIT] | ext_set[1];
    if (ext_is_level[0]) begin
      next_ext_flags[EXT_FLAG_0_BIT] = 1'b0;
    end
    if (ext_is_level[1]) begin
      next_ext_flags[EXT_FLAG_1_BIT] = 1'b0;
    end
    next_ext_flags = next_ext_flags & EXT_FLAGS_VALID;
  end

  // Group flags follow the same order of clear, then set.
  always_comb begin
    next_group_flags = group_flags;
    if (wr_group_flags) begin
      next_group_flags = next_group_flags & ~WR_DATA;
    end
    if (VECTOR_ACK[SRC_GROUP0]) begin
      next_group_flags[GROUP0_BIT] = 1'b0;
    end
    if (VECTOR_ACK[SRC_GROUP1]) begin
      next_group_flags[GROUP1_BIT] = 1'b0;
    end
    if (VECTOR_ACK[SRC_GROUP2]) begin
      next_group_flags[GROUP2_BIT] = 1'b0;
    end
    next_group_flags[2:0] = next_group_flags[2:0] | group_set;
    next_group_flags = next_group_flags & GROUP_FLAGS_VALID;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ext_flags <= RESET_FLAGS;
      group_flags <= RESET_FLAGS;
    end else if (CE) begin
      ext_flags <= next_ext_flags;
      group_flags <= next_group_flags;
    end
  end

  // ----------------------------------------------------------------------
  // Enable and mask registers
  // ----------------------------------------------------------------------
  // These live only in data space, so an I/O space alias never hits them.
  always_ff @(posedge CLK) begin
    if (RST) begin
      group_enable <= RESET_GROUP_ENABLE;
      mask_group0 <= RESET_MASK;
      mask_group1 <= RESET_MASK;
      mask_group2 <= RESET_MASK;
    end else if (CE && WR_EN) begin
      if (acc_addr == ADDR_PIN_CHANGE_GROUP_ENABLE) begin
        group_enable <= WR_DATA & GROUP_ENABLE_VALID;
      end
      if (acc_addr == ADDR_PIN_CHANGE_MASK_GROUP0) begin
        mask_group0 <= WR_DATA & MASK_GROUP0_VALID;
      end
      if (acc_addr == ADDR_PIN_CHANGE_MASK_GROUP1) begin
        mask_group1 <= WR_DATA & MASK_GROUP1_VALID;
      end
      if (acc_addr == ADDR_PIN_CHANGE_MASK_GROUP2) begin
        mask_group2 <= WR_DATA & MASK_GROUP2_VALID;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Unmapped addresses and reserved bits read as zero.
  always_comb begin
    case (acc_addr)
      ADDR_EXTERNAL_IRQ_FLAGS: next_rd_data = ext_flags;
      ADDR_PIN_CHANGE_FLAGS: next_rd_data = group_flags;
      ADDR_PIN_CHANGE_GROUP_ENABLE: next_rd_data = group_enable;
      ADDR_PIN_CHANGE_MASK_GROUP0: next_rd_data = mask_group0;
      ADDR_PIN_CHANGE_MASK_GROUP1: next_rd_data = mask_group1;
      ADDR_PIN_CHANGE_MASK_GROUP2: next_rd_data = mask_group2;
      default: next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RD_DATA <= 8'h00;
    end else if (CE && RD_EN) begin
      RD_DATA <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------------
  // Vector requests
  // ----------------------------------------------------------------------
  // A level source requests straight from the sampled pin, since its flag
  // stays zero; the request drops two clocks after the pin is released, once both synchroniser stages see it.
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      IRQ_REQ[SRC_EXT0 + i] = GLOBAL_IRQ_ENABLE & EXTERNAL_IRQ_ENABLE_MASK[i] &
        (ext_is_level[i] ? ~ext_level[i] : ext_flags[i]);
    end
    IRQ_REQ[SRC_GROUP0] = GLOBAL_IRQ_ENABLE & group_enable[GROUP0_BIT] &
      group_flags[GROUP0_BIT];
    IRQ_REQ[SRC_GROUP1] = GLOBAL_IRQ_ENABLE & group_enable[GROUP1_BIT] &
      group_flags[GROUP1_BIT];
    IRQ_REQ[SRC_GROUP2] = GLOBAL_IRQ_ENABLE & group_enable[GROUP2_BIT] &
      group_flags[GROUP2_BIT];
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_ext_rise_sets;
    @(posedge CLK) disable iff (RST)
      (CE && SENSE_SELECT_0 == EPCF_SENSE_RISE && ext_rise[0]) |=> ext_flags[0];
  endproperty
  a_ext_rise_sets: assert property (p_ext_rise_sets)
    else $error("External flag 0 missed a rising edge.");

  property p_req_needs_global;
    @(posedge CLK) disable iff (RST)
      !GLOBAL_IRQ_ENABLE |-> (IRQ_REQ == '0);
  endproperty
  a_req_needs_global: assert property (p_req_needs_global)
    else $error("Request raised without global enable.");

  property p_ack_clears;
    @(posedge CLK) disable iff (RST)
      (CE && VECTOR_ACK[SRC_GROUP1] && !group_set[GROUP1_BIT]) |=> !group_flags[GROUP1_BIT];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("Acknowledge did not clear group 1 flag.");

  property p_w1c_io;
    @(posedge CLK) disable iff (RST)
      (CE && WR_EN && IO_SPACE && ADDR == 8'(ADDR_PIN_CHANGE_FLAGS - IO_SPACE_OFFSET)
       && WR_DATA[0] && !group_set[0]
       && !VECTOR_ACK[SRC_GROUP0]) |=> !group_flags[0];
  endproperty
  a_w1c_io: assert property (p_w1c_io)
    else $error("I/O space write one did not clear group 0 flag.");

  property p_write_zero_keeps;
    @(posedge CLK) disable iff (RST)
      (CE && wr_ext_flags && !WR_DATA[1] && ext_flags[1] && !VECTOR_ACK[SRC_EXT1]
       && !ext_is_level[1]) |=> ext_flags[1];
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps)
    else $error("Writing zero cleared external flag 1.");

  property p_level_zero;
    @(posedge CLK) disable iff (RST)
      (CE && SENSE_SELECT_1 == EPCF_SENSE_LOW) |=> !ext_flags[1];
  endproperty
  a_level_zero: assert property (p_level_zero)
    else $error("External flag 1 set in level mode.");

  property p_group_disabled;
    @(posedge CLK) disable iff (RST)
      (CE && !group_enable[GROUP2_BIT] && !group_flags[GROUP2_BIT]) |=> !group_flags[GROUP2_BIT];
  endproperty
  a_group_disabled: assert property (p_group_disabled)
    else $error("Disabled group 2 raised its flag.");

  property p_masked_blocks;
    @(posedge CLK) disable iff (RST)
      (CE && !group_flags[GROUP0_BIT] && ((pin_change[7:0] & mask_group0) == 8'h00))
        |=> !group_flags[GROUP0_BIT];
  endproperty
  a_masked_blocks: assert property (p_masked_blocks)
    else $error("Masked pin change set group 0 flag.");

  property p_set_wins;
    @(posedge CLK) disable iff (RST)
      (CE && wr_group_flags && WR_DATA[GROUP2_BIT] && group_set[GROUP2_BIT])
        |=> group_flags[GROUP2_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Clear beat a simultaneous set on group 2.");

  property p_pin_to_flag;
    @(posedge CLK) disable iff (RST)
      (CE && group_enable[GROUP0_BIT] && mask_group0[0] && pin_change[0]) |=> group_flags[0];
  endproperty
  a_pin_to_flag: assert property (p_pin_to_flag)
    else $error("Unmasked change did not set group 0 flag.");

endmodule

// ==== test/epcf_pin_model.sv ====
// Behavioural driver of the external and pin change pins.
`timescale 1ns/10ps
module epcf_pin_model (
  input wire logic clk,
  input wire logic [1:0] ext_cmd,
  input wire logic [23:0] chg_cmd,
  output logic [1:0] ext_pin,
  output logic [23:0] chg_pin
);
  logic [1:0] ext_q = 2'b00;
  logic [23:0] chg_q = 24'h000000;

  // Pins move only just after an edge and then hold a whole period, so each
  // level outlasts one clock and can never slip between two samples.
  always_ff @(posedge clk) begin
    ext_q <= ext_cmd;
    chg_q <= chg_cmd;
  end

  // The pins are driven like port outputs, which still must interrupt.
  assign ext_pin = ext_q;
  assign chg_pin = chg_q;
endmodule

// ==== test/epcf_top_bench.sv ====
// Self-checking bench for the external and pin change interrupt flag block.
`timescale 1ns/10ps
module epcf_top_bench;
  import epcf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic io_space = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic [1:0] ext_pin;
  logic [1:0] sense0 = 2'b11;
  logic [1:0] sense1 = 2'b11;
  logic [1:0] ext_en = 2'b11;
  logic gie = 1'b1;
  logic [23:0] chg_pin;
  logic [4:0] ack = 5'h00;
  logic [4:0] irq_req;
  logic [1:0] ext_cmd = 2'b00;
  logic [23:0] chg_cmd = 24'h000000;
  int miscompares = 0;
  int cmp_count = 0;

  // ----------------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------------
  // The 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end

  epcf_pin_model pins (.clk(clk), .ext_cmd(ext_cmd), .chg_cmd(chg_cmd),
    .ext_pin(ext_pin), .chg_pin(chg_pin));

  epcf_top dut (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .IO_SPACE(io_space),
    .WR_EN(wr_en), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_DATA(rd_data),
    .EXT_PIN(ext_pin), .SENSE_SELECT_0(sense0), .SENSE_SELECT_1(sense1),
    .EXTERNAL_IRQ_ENABLE_MASK(ext_en), .GLOBAL_IRQ_ENABLE(gie),
    .CHANGE_WATCH_PIN(chg_pin), .VECTOR_ACK(ack), .IRQ_REQ(irq_req));

  // ----------------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Waits whole cycles and returns on an edge, so stimulus stays edge aligned.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One write strobe; the strobe drops at the next edge.
  task automatic wr(input logic sp, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_space <= sp;
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // One read strobe; the data loaded at the strobe's edge is compared one edge
  // later, where the strobe is gone and the register cannot move.
  task automatic rd(input logic sp, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    io_space <= sp;
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    chk(rd_data, exp, "read data");
  endtask

  // Request lines are combinational from flags, so they are looked at once
  // the edge has settled; the task then returns on the next edge.
  task automatic irq(input logic [4:0] exp);
    #1;
    chk({3'b000, irq_req}, {3'b000, exp}, "request lines");
    @(posedge clk);
  endtask

  // A hang would otherwise never reach the verdict.
  initial begin
    #2000000;
    miscompares++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] regs [6];
    logic [7:0] backs [6];
    int pinx [3];
    logic [7:0] bit_p;
    regs = '{8'h3b, 8'h3c, 8'h68, 8'h6b, 8'h6c, 8'h6d};
    backs = '{8'h00, 8'h00, 8'h07, 8'hff, 8'h7f, 8'hff};
    pinx = '{0, 14, 23};
    cyc(4);
    rst <= 1'b0;

    // Reset values, read-only corners, unmapped places and I/O space aliases.
    for (int i = 0; i < 6; i++) rd(1'b0, regs[i], 8'h00);
    rd(1'b1, 8'h1b, 8'h00);
    rd(1'b1, 8'h1c, 8'h00);
    for (int i = 2; i < 6; i++) wr(1'b0, regs[i], 8'hff);
    wr(1'b0, 8'h3c, 8'hff);
    for (int i = 0; i < 6; i++) rd(1'b0, regs[i], backs[i]);
    rd(1'b1, 8'h48, 8'h00);
    rd(1'b0, 8'h50, 8'h00);
    wr(1'b0, 8'h68, 8'h00);
    $display("test registers done");

    // Every edge code on both pins, with the pin rising and then falling.
    for (int p = 0; p < 2; p++) begin
      bit_p = 8'h01 << p;
      for (int c = 1; c < 4; c++) begin
        sense0 <= 2'(c);
        sense1 <= 2'(c);
        ext_cmd[p] <= 1'b1;
        cyc(6);
        rd(1'b1, 8'h1c, (c != 2) ? bit_p : 8'h00);
        irq((c != 2) ? bit_p[4:0] : 5'h00);
        wr(1'b1, 8'h1c, 8'h03);
        ext_cmd[p] <= 1'b0;
        cyc(6);
        rd(1'b1, 8'h1c, (c != 3) ? bit_p : 8'h00);
        wr(1'b1, 8'h1c, 8'h03);
        rd(1'b0, 8'h3c, 8'h00);
      end
    end
    $display("test edge sensing done");

    // Low level: the flag stays clear while the request follows the pin.
    sense0 <= 2'b00;
    sense1 <= 2'b00;
    cyc(4);
    rd(1'b1, 8'h1c, 8'h00);
    irq(5'h03);
    ext_cmd[0] <= 1'b1;
    cyc(5);
    irq(5'h02);
    rd(1'b0, 8'h3c, 8'h00);
    $display("test level sensing done");

    // A zero write leaves both flags, a disabled source stays quiet, and one
    // acknowledge clears only its own flag.
    sense0 <= 2'b11;
    sense1 <= 2'b11;
    ext_cmd <= 2'b00;
    cyc(4);
    ext_cmd <= 2'b11;
    cyc(6);
    wr(1'b0, 8'h3c, 8'h00);
    rd(1'b0, 8'h3c, 8'h03);
    ext_en <= 2'b01;
    cyc(1);
    irq(5'h01);
    ext_en <= 2'b11;
    @(posedge clk);
    ack <= 5'h01;
    @(posedge clk);
    ack <= 5'h00;
    cyc(1);
    irq(5'h02);
    rd(1'b1, 8'h1c, 8'h02);
    wr(1'b1, 8'h1c, 8'h02);
    rd(1'b1, 8'h1c, 8'h00);
    $display("test clearing done");

    // One watched pin for each group, then masked, disabled and ungated cases.
    wr(1'b0, 8'h6b, 8'h01);
    wr(1'b0, 8'h6c, 8'h40);
    wr(1'b0, 8'h6d, 8'h80);
    wr(1'b0, 8'h68, 8'h07);
    for (int g = 0; g < 3; g++) begin
      chg_cmd[pinx[g]] <= ~chg_cmd[pinx[g]];
      cyc(6);
      rd(1'b1, 8'h1b, 8'h01 << g);
      irq(5'h04 << g);
      if (g == 1) begin
        ack <= 5'h08;
        cyc(1);
        ack <= 5'h00;
        cyc(1);
        rd(1'b0, 8'h3b, 8'h00);
      end
      wr(1'b1, 8'h1b, 8'h07);
    end
    chg_cmd[1] <= 1'b1;
    chg_cmd[15] <= 1'b1;
    chg_cmd[22] <= 1'b1;
    cyc(6);
    rd(1'b1, 8'h1b, 8'h00);
    wr(1'b0, 8'h68, 8'h00);
    chg_cmd[0] <= 1'b0;
    cyc(6);
    rd(1'b0, 8'h3b, 8'h00);
    wr(1'b0, 8'h68, 8'h07);
    gie <= 1'b0;
    chg_cmd[23] <= 1'b0;
    cyc(6);
    rd(1'b0, 8'h3b, 8'h04);
    irq(5'h00);
    gie <= 1'b1;
    cyc(1);
    irq(5'h10);
    wr(1'b0, 8'h3b, 8'h04);
    rd(1'b0, 8'h3b, 8'h00);
    // The change reaches the flag logic at the very edge of the clearing write.
    chg_cmd[23] <= 1'b1;
    cyc(2);
    wr(1'b0, 8'h3b, 8'h04);
    rd(1'b0, 8'h3b, 8'h04);
    // With the clock enable low a clearing write is lost.
    ce <= 1'b0;
    wr(1'b0, 8'h3b, 8'h04);
    ce <= 1'b1;
    rd(1'b0, 8'h3b, 8'h04);
    wr(1'b0, 8'h3b, 8'h04);
    rd(1'b0, 8'h3b, 8'h00);
    $display("test pin change groups done");
    end_sim();
  end
endmodule
